/* verilog/quad_out_pkg.sv */
/*
  Shared constants and carriers for the incremental angle output block:
  layout and reset value of the control word, timing figures, pin bundle.
  Assumes a single 125 MHz system clock drives every user of this package.
*/
package quad_out_pkg;

  // Register location and reset value of the control word
  localparam logic [7:0] CTRL_OFFSET = 8'h19;
  localparam logic [23:0] CTRL_RESET = 24'h081024;
  // Writable bits; the rest are reserved and read as zero
  localparam logic [23:0] CTRL_RW_MASK = 24'h3f93ff;

  // Field positions
  localparam int SPACING_LSB = 16;
  localparam int SWAP_BIT = 15;
  localparam int HYST_EN_BIT = 12;
  localparam int INDEX_LSB = 8;
  localparam int OSC_FORCE_BIT = 7;
  localparam int PLL_FORCE_BIT = 6;
  localparam int OUT_EN_BIT = 5;
  localparam int COMM_SEL_BIT = 4;
  localparam int RES_LSB = 0;

  // Angle and resolution figures
  localparam int ANGLE_W = 14;
  localparam logic [3:0] RES_MIN = 4'h3;
  localparam logic [3:0] RES_MAX = 4'he;

  // Timing: one spacing unit and the clock period, both in ns
  localparam int SPACING_UNIT_NS = 125;
  localparam int CLK_PERIOD_NS = 8;

  typedef struct packed {
    logic [1:0] rsv_top;
    logic [5:0] edge_spacing_limit;
    logic output_polarity_swap;
    logic [1:0] rsv_mid;
    logic incremental_hysteresis_enable;
    logic [1:0] rsv_low;
    logic [1:0] index_window;
    logic osc_fault_force_high;
    logic pll_fault_force_high;
    logic incremental_output_enable;
    logic commutation_select;
    logic [3:0] resolution;
  } ctrl_s;

  // One bundle carries all three pin groups: A/U, B/V, I/W
  typedef struct packed {
    logic a_u;
    logic b_v;
    logic i_w;
  } pins_s;

endpackage

/* verilog/quadrature_commutation_output.sv */
/*
  Incremental angle output: turns the processed angle into quadrature A/B/I
  or U/V/W commutation levels, with edge spacing, hysteresis, polarity swap
  and fault forcing. Assumes angle and fault flags come from logic on sys_clk.
*/
`timescale 1ns/10ps
module quadrature_commutation_output (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic ctrl_wr,
  input wire logic [23:0] ctrl_wdata,
  output logic [23:0] ctrl_rdata,
  input wire logic [13:0] angle,
  input wire logic [5:0] hysteresis,
  input wire logic oscillator_frequency_fault,
  input wire logic pll_lock_lost,
  output quad_out_pkg::pins_s pin_out,
  output quad_out_pkg::pins_s pin_oe,
  output logic [13:0] track_pos
);

  // Cycles per spacing setting, rounded up since it is a least time
  function automatic logic [10:0] spacing_cycles(input logic [5:0] n);
    int t;
    t = ((int'(n) + 1) * quad_out_pkg::SPACING_UNIT_NS + quad_out_pkg::CLK_PERIOD_NS - 1)
        / quad_out_pkg::CLK_PERIOD_NS;
    return t[10:0];
  endfunction

  // Angle weight of one quadrature state for resolution n (valid n only)
  function automatic logic [13:0] step_size(input logic [3:0] n);
    return 14'h0001 << (n - 4'h2);
  endfunction

  quad_out_pkg::ctrl_s ctrl, next_ctrl;
  logic [13:0] held, next_held;
  logic [13:0] next_pos;
  logic [10:0] timer, next_timer;
  quad_out_pkg::pins_s next_out, next_oe;
  logic res_ok, force_high, edge_step;
  logic [13:0] step, diff, hdiff, hmag, rel;
  logic [1:0] phase;
  logic [16:0] elec6;
  logic [13:0] elec;
  logic [2:0] sector, phase_code;

  assign ctrl_rdata = ctrl;

  // Control word; reserved bits are masked so they stay zero
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl = quad_out_pkg::ctrl_s'(ctrl_wdata & quad_out_pkg::CTRL_RW_MASK);
    end
  end

  // Angle path and tracking position
  always_comb begin
    hdiff = angle - held;
    hmag = hdiff[13] ? 14'(-hdiff) : hdiff;
    next_held = held;
    if (!ctrl.incremental_hysteresis_enable || (hmag > {8'h00, hysteresis})) begin
      next_held = angle;
    end
    res_ok = (ctrl.resolution >= quad_out_pkg::RES_MIN) && (ctrl.resolution <= quad_out_pkg::RES_MAX);
    step = res_ok ? step_size(ctrl.resolution) : 14'h0001;
    diff = (held & ~(step - 14'h0001)) - track_pos;
    edge_step = res_ok && !ctrl.commutation_select && (diff != 14'h0000) && (timer == 11'h000);
    // one state per allowed edge, so a jump is walked out at the spaced rate
    next_pos = track_pos;
    next_timer = (timer != 11'h000) ? timer - 11'h001 : timer;
    if (edge_step) begin
      next_pos = diff[13] ? track_pos - step : track_pos + step;
      next_timer = (ctrl.edge_spacing_limit == 6'h00) ? 11'h000
                   : spacing_cycles(ctrl.edge_spacing_limit) - 11'h001;
    end
  end

  // Pin levels
  always_comb begin
    phase = 2'(track_pos >> (ctrl.resolution - 4'h2));
    rel = track_pos;
    // six sectors of the electrical angle
    // electrical angle scaled by pole pairs
    elec = 14'(held * ({10'h000, ctrl.resolution} + 14'h0001));
    elec6 = {3'h0, elec} * 17'h00006;
    sector = elec6[16:14];
    unique case (sector)
      3'h0: phase_code = 3'h4;
      3'h1: phase_code = 3'h6;
      3'h2: phase_code = 3'h2;
      3'h3: phase_code = 3'h3;
      3'h4: phase_code = 3'h1;
      default: phase_code = 3'h5;
    endcase
    next_out = ctrl.commutation_select ? quad_out_pkg::pins_s'(phase_code)
               : quad_out_pkg::pins_s'({phase[1], phase[1] ^ phase[0], 1'b0});
    if (!ctrl.commutation_select) begin
      unique case (ctrl.index_window)
        2'h0: next_out.i_w = (rel == 14'h0000);
        2'h1: next_out.i_w = (rel == 14'h0000) || (rel == 14'(-step));
        2'h2: next_out.i_w = (rel == 14'h0000) || (rel == 14'(-step)) || (rel == step);
        default: next_out.i_w = (rel == 14'h0000) || (rel == 14'(-step)) || (rel == step)
                                || (rel == 14'(-(step << 1)));
      endcase
      if (!res_ok) begin
        next_out = '0;
      end
    end
    // Oscillator and PLL fault forcing; both act before the polarity swap
    // flags come straight from the on-chip monitors
    force_high = (ctrl.osc_fault_force_high && oscillator_frequency_fault)
                 || (ctrl.pll_fault_force_high && pll_lock_lost);
    if (force_high) begin
      next_out = '1;
    end
    if (ctrl.output_polarity_swap) begin
      next_out = ~next_out;
    end
    // pins idle and undriven while disabled
    next_oe = ctrl.incremental_output_enable ? '1 : '0;
    if (!ctrl.incremental_output_enable) begin
      next_out = '0;
    end
  end

  // State registers; clk_en low freezes everything
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= quad_out_pkg::ctrl_s'(quad_out_pkg::CTRL_RESET);
      held <= 14'h0000;
      track_pos <= 14'h0000;
      timer <= 11'h000;
      pin_out <= '0;
      pin_oe <= '0;
    end else if (clk_en) begin
      ctrl <= next_ctrl;
      held <= next_held;
      track_pos <= next_pos;
      timer <= next_timer;
      pin_out <= next_out;
      pin_oe <= next_oe;
    end
  end

  // Helper: cycles since the last quadrature step, saturating
  logic [10:0] since_step;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_step <= 11'h7ff;
    end else if (clk_en) begin
      since_step <= edge_step ? 11'h001 : ((since_step == 11'h7ff) ? since_step : since_step + 11'h001);
    end
  end

  spacing_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    edge_step && ctrl.edge_spacing_limit != 6'h00 |-> since_step >= spacing_cycles(ctrl.edge_spacing_limit))
    else $error("quadrature edges closer than spacing limit");

  // A step lands in track_pos one edge later and on the pins the edge after that
  gray_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && edge_step && !force_high && ctrl.incremental_output_enable && !ctrl_wr
    ##1 clk_en && !force_high
    |=> $countones({pin_out.a_u, pin_out.b_v} ^ $past({pin_out.a_u, pin_out.b_v})) == 1)
    else $error("quadrature step did not move exactly one of A and B");

  hyst_raw_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && !ctrl.incremental_hysteresis_enable |=> held == $past(angle))
    else $error("angle held although hysteresis disabled");

  index_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && ctrl.incremental_output_enable && !ctrl.commutation_select && !force_high && res_ok
    && ctrl.index_window == 2'h0 && !ctrl_wr |=> pin_out.i_w == (($past(track_pos) == 14'h0000) ^ ctrl.output_polarity_swap))
    else $error("index pulse outside zero window");

  osc_force_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && ctrl.incremental_output_enable && ctrl.osc_fault_force_high && oscillator_frequency_fault
    && !ctrl_wr |=> pin_out == {3{~ctrl.output_polarity_swap}})
    else $error("outputs not forced on oscillator fault");

  pll_force_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && ctrl.incremental_output_enable && ctrl.pll_fault_force_high && pll_lock_lost
    && !ctrl_wr |=> pin_out == {3{~ctrl.output_polarity_swap}})
    else $error("outputs not forced on PLL lock loss");

  disabled_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && !ctrl.incremental_output_enable && !ctrl_wr |=> pin_oe == '0 && pin_out == '0)
    else $error("pins active while output disabled");

  comm_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_en && ctrl.incremental_output_enable && ctrl.commutation_select && !force_high && !ctrl_wr
    |=> pin_out != {3{ctrl.output_polarity_swap}} && pin_out != {3{~ctrl.output_polarity_swap}})
    else $error("illegal commutation code");

endmodule // quadrature_commutation_output

/* sim/quad_decoder.sv */
/*
  Behavioural controller that decodes the A/B pins into a position count
  and records the time between the last two pin edges.
  Assumes non-inverted polarity and quadrature mode while it counts.
*/
`timescale 1ns/10ps
module quad_decoder (
  input wire logic a,
  input wire logic b,
  output int edge_count,
  output int edge_gap_ns
);
  logic [1:0] st;
  realtime last;
  // Gray order 00,01,11,10 mapped to 0..3
  function automatic logic [1:0] ord(input logic [1:0] ab);
    return {ab[1], ab[1] ^ ab[0]};
  endfunction
  initial begin
    edge_count = 0;
    edge_gap_ns = 0;
    last = 0;
    st = 2'h0;
  end
  always @(a or b) begin
    case (2'(ord({a, b}) - ord(st)))
      2'h1: edge_count++;
      2'h3: edge_count--; // Reverse step
      default: ; // Illegal jump: a real decoder loses count here
    endcase
    edge_gap_ns = int'($realtime - last);
    last = $realtime;
    st = {a, b};
  end
endmodule // quad_decoder

/* sim/quadrature_commutation_output_tb.sv */
/*
  Self-checking bench: control word access, quadrature, index, forcing,
  enable, hysteresis, commutation and edge spacing.
  Assumes the design and package under verilog/ are compiled first.
*/
`timescale 1ns/10ps
module quadrature_commutation_output_tb;
  logic sys_clk, sys_rst, clk_en, ctrl_wr, oscillator_frequency_fault, pll_lock_lost;
  logic [23:0] ctrl_wdata, ctrl_rdata;
  logic [13:0] angle, track_pos;
  logic [5:0] hysteresis;
  quad_out_pkg::pins_s pin_out, pin_oe;
  int fails, compares, cnt0, edge_count, edge_gap_ns;
  logic [1:0] ab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [3:0] iw [4] = '{4'h4, 4'h6, 4'he, 4'hf};
  logic [2:0] sector_code [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  quadrature_commutation_output u_quadrature_commutation_output (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .angle(angle),
    .hysteresis(hysteresis), .oscillator_frequency_fault(oscillator_frequency_fault),
    .pll_lock_lost(pll_lock_lost), .pin_out(pin_out), .pin_oe(pin_oe), .track_pos(track_pos));
  quad_decoder u_quad_decoder (.a(pin_out.a_u), .b(pin_out.b_v), .edge_count(edge_count),
    .edge_gap_ns(edge_gap_ns));
  // Clock at 8 ns period
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [23:0] w);
    ctrl_wr = 1;
    ctrl_wdata = w;
    tick(1);
    ctrl_wr = 0;
  endtask
  // Compose a control word: spacing, swap, hysteresis, index, forces, enable, mode, resolution
  function automatic logic [23:0] cw(int n, sw, hy, ix, fo, fp, oe, cm, rs);
    return 24'((n << 16) | (sw << 15) | (hy << 12) | (ix << 8) | (fo << 7) | (fp << 6) | (oe << 5) | (cm << 4) | rs);
  endfunction
  task mv(input int a);
    angle = 14'(a);
    tick(12);
  endtask
  task test_done;
    $display("TB: compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #200000;
    fails++;
    test_done;
  end
  initial begin
    sys_rst = 1;
    clk_en = 1;
    ctrl_wr = 0;
    ctrl_wdata = 0;
    angle = 0;
    hysteresis = 0;
    oscillator_frequency_fault = 0;
    pll_lock_lost = 0;
    tick(20);
    sys_rst = 0;
    chk("ctrl reset", ctrl_rdata, quad_out_pkg::CTRL_RESET);
    tick(1);
    chk("oe after reset", 24'(pin_oe), 24'h7);
    wr(24'hffffff);
    chk("reserved bits", ctrl_rdata, quad_out_pkg::CTRL_RW_MASK);
    // Let an edge pass so the strobe is not raised again in the step that lowered it
    tick(1);
    clk_en = 0;
    wr(24'h0);
    clk_en = 1;
    chk("frozen write", ctrl_rdata, quad_out_pkg::CTRL_RW_MASK);
    $display("TB: registers done");
    // Each phase of one cycle, plain then swapped; index mode 0 at zero
    for (int sw = 0; sw < 2; sw++) begin
      wr(cw(0, sw, 0, 0, 0, 0, 1, 0, 4));
      for (int k = 0; k < 5; k++) begin
        mv(k * 4);
        chk("ab phase", 24'(pin_out), 24'({ab[k % 4], k == 0} ^ {3{sw[0]}}));
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr(cw(0, 0, 0, m, 0, 0, 1, 0, 4));
      for (int d = -2; d < 2; d++) begin
        mv(d * 4);
        chk("index", 24'(pin_out.i_w), 24'(iw[m][d + 2]));
      end
    end
    $display("TB: quadrature done");
    // Fault flags are driven straight from the bench
    wr(cw(0, 1, 0, 0, 1, 0, 1, 0, 4));
    mv(4);
    chk("swapped normal", 24'(pin_out), 24'h5);
    oscillator_frequency_fault = 1;
    tick(4);
    chk("osc force", 24'(pin_out), 24'h0);
    oscillator_frequency_fault = 0;
    pll_lock_lost = 1;
    tick(4);
    chk("pll ignored", 24'(pin_out), 24'h5);
    wr(cw(0, 1, 0, 0, 0, 1, 1, 0, 4));
    tick(4);
    chk("pll force", 24'(pin_out), 24'h0);
    pll_lock_lost = 0;
    wr(cw(0, 0, 0, 0, 0, 0, 0, 0, 4));
    tick(4);
    chk("disabled pins", 24'(pin_out), 24'h0);
    chk("disabled oe", 24'(pin_oe), 24'h0);
    $display("TB: force and enable done");
    hysteresis = 6'h14;
    wr(cw(0, 0, 0, 0, 0, 0, 1, 0, 4));
    mv(0);
    wr(cw(0, 0, 1, 0, 0, 0, 1, 0, 4));
    mv(12);
    chk("hyst hold", 24'(track_pos), 24'h0);
    mv(24);
    chk("hyst pass", 24'(track_pos), 24'h18);
    wr(cw(0, 0, 0, 0, 0, 0, 1, 0, 4));
    mv(28);
    chk("hyst off", 24'(track_pos), 24'h1c);
    wr(cw(0, 0, 0, 0, 0, 0, 1, 0, 15));
    mv(60);
    chk("bad res pins", 24'(pin_out), 24'h000000);
    chk("bad res frozen", 24'(track_pos), 24'h00001c);
    $display("TB: hysteresis done");
    // Points 300 past each sector start, kept clear of boundaries for one and four pole pairs
    for (int p = 0; p < 4; p += 3) begin
      wr(cw(0, 0, 0, 0, 0, 0, 1, 1, p));
      for (int k = 0; k < 6; k++) begin
        mv((k * 2731 + 300) / (p + 1));
        chk("comm sector", 24'(pin_out), 24'(sector_code[k]));
      end
    end
    $display("TB: commutation done");
    wr(cw(0, 0, 0, 0, 0, 0, 1, 0, 4));
    angle = 0;
    tick(1100);
    // spacing kept low enough for the move
    wr(cw(1, 0, 0, 0, 0, 0, 1, 0, 4));
    cnt0 = edge_count;
    angle = 14'h28;
    tick(400);
    chk("edge gap", 24'(edge_gap_ns), 24'(((2 * 125 + 7) / 8) * 8));
    chk("step count", 24'(edge_count - cnt0), 24'h00000a);
    $display("TB: spacing done");
    test_done;
  end
endmodule // quadrature_commutation_output_tb
